// ===== rtl/usart_master_spi_transfer.sv
// usart master spi transfer: registers, shifters, baud and buffers
`timescale 1ns/1ps
`default_nettype none
`include "usart_spi_defines.svh"

module usart_master_spi_transfer (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [2:0] address_i,
  input wire logic [7:0] write_data_i,
  input wire logic write_strobe_i,
  input wire logic read_strobe_i,
  output logic [7:0] read_data_o,
  input wire logic global_irq_enable_i,
  input wire logic tx_complete_irq_ack_i,
  input wire logic port_out_i,
  output logic serial_out_pin_o,
  output logic serial_out_override_o,
  input wire logic serial_in_pin_i,
  output logic serial_in_override_o,
  output logic transfer_clock_pin_o,
  output logic rx_complete_irq_o,
  output logic tx_complete_irq_o,
  output logic buffer_empty_irq_o
);

  usart_spi_pkg::spi_regs_t s_q;
  usart_spi_pkg::spi_regs_t s_d;

  logic rxc_now;
  logic udre_now;
  logic frame_end;

  assign rxc_now = (s_q.rx_count != 2'h0);
  assign udre_now = ~s_q.buf_full;

  always_comb begin
    logic tick;
    logic lead;
    logic smp;
    logic shf;
    logic fend;
    logic load;
    logic lsb;
    logic pha;
    logic rx_on;
    logic [7:0] rx_new;
    logic [1:0] cnt_pop;
    s_d = s_q;
    tick = 1'b0;
    lead = ~s_q.half[0];
    smp = 1'b0;
    shf = 1'b0;
    fend = 1'b0;
    load = 1'b0;
    // mode bits shared by transmitter and receiver
    lsb = s_q.cfg[`CFG_ORDER]; // R13
    pha = s_q.cfg[`CFG_PHASE]; // R13
    rx_on = s_q.ctrl[`CTL_RXEN];
    rx_new = s_q.rx_sr;
    cnt_pop = s_q.rx_count;

    unique case (s_q.state)
      usart_spi_pkg::ST_IDLE: begin
        s_d.sck = s_q.cfg[`CFG_POL]; // R24
        s_d.cnt = 12'h000;
        s_d.half = `HALF_FIRST;
        // start when a byte waits and the transmitter runs
        load = s_q.tx_on && s_q.buf_full; // R05 R06
      end
      usart_spi_pkg::ST_SHIFT: begin
        // half period is divisor plus one system clocks
        tick = (s_q.cnt == s_q.baud); // R26
        if (tick) begin
          s_d.cnt = 12'h000;
        end else begin
          s_d.cnt = s_q.cnt + 12'h001;
        end
        if (tick) begin
          s_d.sck = ~s_q.sck; // R04
          s_d.half = s_q.half + 4'h1; // R23
          // opposite edges for sampling and shifting
          smp = pha ? ~lead : lead; // R24
          shf = pha ? (lead && s_q.half != `HALF_FIRST)
                    : (!lead && s_q.half != `HALF_LAST); // R24
          fend = (s_q.half == `HALF_LAST); // R23
        end
      end
      default: begin
        s_d.state = usart_spi_pkg::ST_IDLE;
      end
    endcase

    // receive shifter only listens while the receiver owns the pin
    if (smp && rx_on) begin // R03
      if (lsb) begin
        rx_new = {serial_in_pin_i, s_q.rx_sr[7:1]}; // R25
      end else begin
        rx_new = {s_q.rx_sr[6:0], serial_in_pin_i}; // R25
      end
    end
    s_d.rx_sr = rx_new;

    if (shf) begin
      if (lsb) begin
        s_d.tx_sr = {1'b1, s_q.tx_sr[7:1]}; // R25
      end else begin
        s_d.tx_sr = {s_q.tx_sr[6:0], 1'b1}; // R25
      end
    end

    // back to back frame when the buffer already holds the next byte
    if (fend) begin
      load = s_q.tx_on && s_q.buf_full; // R23
    end

    if (load) begin
      s_d.tx_sr = s_q.tx_buf; // R06
      s_d.buf_full = 1'b0; // R10
      s_d.state = usart_spi_pkg::ST_SHIFT; // R05
      s_d.cnt = 12'h000;
      s_d.half = `HALF_FIRST;
      s_d.sck = s_q.cfg[`CFG_POL];
    end else if (fend) begin
      s_d.state = usart_spi_pkg::ST_IDLE;
    end

    // receive fifo: pop on a data read, then push the new byte
    if (read_strobe_i && address_i == `ADDR_DATA && rxc_now) begin
      s_d.rx_buf[0] = s_q.rx_buf[1];
      cnt_pop = s_q.rx_count - 2'h1;
    end
    s_d.rx_count = cnt_pop;
    if (fend && rx_on) begin
      // full fifo keeps its older bytes and drops this one
      if (cnt_pop != `RX_DEPTH) begin // R08
        s_d.rx_buf[cnt_pop[0]] = rx_new;
        s_d.rx_count = cnt_pop + 2'h1;
      end
    end
    if (!rx_on) begin
      s_d.rx_count = 2'h0; // R15
    end

    // register writes
    if (write_strobe_i) begin
      case (address_i)
        `ADDR_STATUS: begin
          if (write_data_i[`ST_TXC]) begin
            s_d.txc = 1'b0; // R17
          end
        end
        `ADDR_CONTROL: begin
          s_d.ctrl = write_data_i & `CTL_MASK;
        end
        `ADDR_CONFIG: begin
          s_d.cfg = write_data_i[2:0]; // R13
        end
        `ADDR_BAUD_LO: begin
          s_d.baud[7:0] = write_data_i; // R11
        end
        `ADDR_BAUD_HI: begin
          s_d.baud[11:8] = write_data_i[3:0]; // R11
        end
        `ADDR_DATA: begin
          // a write to a full buffer is dropped without any flag
          if (!s_d.buf_full) begin // R11
            s_d.tx_buf = write_data_i; // R10
            s_d.buf_full = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
    if (tx_complete_irq_ack_i) begin
      s_d.txc = 1'b0; // R17
    end
    // completion wins over a clear in the same cycle
    if (fend && !load) begin
      s_d.txc = 1'b1; // R16
    end

    // transmitter stays on until shifter and buffer are drained
    s_d.tx_on = s_d.ctrl[`CTL_TXEN]
              | (s_q.tx_on
                 & ((s_q.state == usart_spi_pkg::ST_SHIFT)
                    | s_q.buf_full)); // R28

    // serial out pin: shift data while shifting, high while owned and idle, else the port value
    if (s_d.tx_on) begin // R02
      if (s_d.state == usart_spi_pkg::ST_SHIFT) begin
        s_d.sout = lsb ? s_d.tx_sr[0] : s_d.tx_sr[7]; // R12
      end else begin
        s_d.sout = 1'b1;
      end
    end else begin
      s_d.sout = port_out_i; // R28
    end

    // read data stands only in the cycle after the strobe
    s_d.rdata = 8'h00;
    if (read_strobe_i) begin
      case (address_i)
        `ADDR_STATUS: begin
          // error bits of the async modes read as zero
          s_d.rdata = {rxc_now, s_q.txc, udre_now, 5'h00}; // R09 R14 R18
        end
        `ADDR_CONTROL: begin
          s_d.rdata = s_q.ctrl;
        end
        `ADDR_CONFIG: begin
          s_d.rdata = {5'h00, s_q.cfg};
        end
        `ADDR_BAUD_LO: begin
          s_d.rdata = s_q.baud[7:0];
        end
        `ADDR_BAUD_HI: begin
          s_d.rdata = {4'h0, s_q.baud[11:8]};
        end
        `ADDR_DATA: begin
          s_d.rdata = s_q.rx_buf[0];
        end
        default: begin
          s_d.rdata = 8'h00;
        end
      endcase
    end

    // interrupt requests, gated by global flag and enables
    s_d.rx_irq = s_q.ctrl[`CTL_RXCIE] & global_irq_enable_i
               & rxc_now; // R21
    s_d.tx_irq = s_q.ctrl[`CTL_TXCIE] & global_irq_enable_i
               & s_q.txc; // R22
    s_d.udre_irq = s_q.ctrl[`CTL_BUFFER_EMPTY_IRQ_ENABLE] & global_irq_enable_i
                 & udre_now; // R27
  end

  assign frame_end = (s_q.state == usart_spi_pkg::ST_SHIFT)
                   && (s_q.cnt == s_q.baud)
                   && (s_q.half == `HALF_LAST);

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
      s_q.state <= usart_spi_pkg::ST_IDLE;
      s_q.cfg <= `CFG_RESET;
      // empty buffer, so the empty flag reads set
      s_q.buf_full <= 1'b0; // R19
    end else begin
      s_q <= s_d;
    end
  end

  assign read_data_o = s_q.rdata;
  assign serial_out_pin_o = s_q.sout;
  assign serial_out_override_o = s_q.tx_on;
  assign serial_in_override_o = s_q.ctrl[`CTL_RXEN];
  assign transfer_clock_pin_o = s_q.sck;
  assign rx_complete_irq_o = s_q.rx_irq;
  assign tx_complete_irq_o = s_q.tx_irq;
  assign buffer_empty_irq_o = s_q.udre_irq;

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);

  a_status_zero_bits: assert property ( // R09
    (read_strobe_i && address_i == `ADDR_STATUS)
    |=> read_data_o[4:0] == 5'h00)
    else $error("reserved status bits not zero");

  a_rxc_reads_level: assert property ( // R14
    (read_strobe_i && address_i == `ADDR_STATUS)
    |=> read_data_o[`ST_RXC] == ($past(s_q.rx_count) != 2'h0))
    else $error("receive complete flag wrong");

  a_udre_reads_free: assert property ( // R18
    (read_strobe_i && address_i == `ADDR_STATUS)
    |=> read_data_o[`ST_UDRE] == !$past(s_q.buf_full))
    else $error("buffer empty flag wrong");

  a_rx_flush: assert property ( // R15
    !s_q.ctrl[`CTL_RXEN] |=> s_q.rx_count == 2'h0)
    else $error("receive buffer not flushed");

  a_overflow_keeps: assert property ( // R08
    (frame_end && s_q.rx_count == `RX_DEPTH
     && s_q.ctrl[`CTL_RXEN]
     && !(read_strobe_i && address_i == `ADDR_DATA))
    |=> $stable(s_q.rx_buf) && s_q.rx_count == `RX_DEPTH)
    else $error("overflow damaged older bytes");

  a_txc_on_end: assert property ( // R16
    (frame_end && !s_q.buf_full) |=> s_q.txc
    ##0 s_q.state == usart_spi_pkg::ST_IDLE)
    else $error("transmit complete not set");

  a_txc_clear: assert property ( // R17
    (tx_complete_irq_ack_i && !frame_end) |=> !s_q.txc)
    else $error("transmit complete not cleared");

  a_rx_irq_gate: assert property ( // R21
    rx_complete_irq_o |-> $past(global_irq_enable_i)
    && $past(s_q.ctrl[`CTL_RXCIE]) && $past(s_q.rx_count) != 2'h0)
    else $error("receive interrupt without cause");

  a_tx_irq_gate: assert property ( // R22
    (s_q.ctrl[`CTL_TXCIE] && global_irq_enable_i && s_q.txc)
    |=> tx_complete_irq_o)
    else $error("transmit interrupt missing");

  a_pin_release: assert property ( // R02
    !s_d.tx_on |=> serial_out_pin_o == $past(port_out_i)
    && !serial_out_override_o)
    else $error("serial out not released");

  a_tx_hold: assert property ( // R28
    (s_q.tx_on && s_q.buf_full) |=> s_q.tx_on)
    else $error("transmitter stopped with data pending");

  a_sck_idle: assert property ( // R24
    (s_q.state == usart_spi_pkg::ST_IDLE
     && $past(s_q.state) == usart_spi_pkg::ST_IDLE
     && $stable(s_q.cfg))
    |-> transfer_clock_pin_o == s_q.cfg[`CFG_POL])
    else $error("idle clock level wrong");

  a_load_takes_buf: assert property ( // R06
    (s_q.state == usart_spi_pkg::ST_IDLE && s_q.tx_on && s_q.buf_full)
    |=> s_q.state == usart_spi_pkg::ST_SHIFT
    && s_q.tx_sr == $past(s_q.tx_buf))
    else $error("buffered byte not loaded");

  a_udre_irq_gate: assert property ( // R27
    buffer_empty_irq_o |-> $past(global_irq_enable_i)
    && $past(s_q.ctrl[`CTL_BUFFER_EMPTY_IRQ_ENABLE]) && !$past(s_q.buf_full))
    else $error("empty interrupt without cause");

  a_rx_first_push: assert property ( // R14
    (frame_end && s_q.ctrl[`CTL_RXEN] && s_q.rx_count == 2'h0)
    |=> s_q.rx_count == 2'h1)
    else $error("received byte not buffered");

  a_txc_write_clear: assert property ( // R17
    (write_strobe_i && address_i == `ADDR_STATUS
     && write_data_i[`ST_TXC] && !frame_end)
    |=> !s_q.txc)
    else $error("transmit complete not cleared by write");

endmodule
`default_nettype wire

// ===== rtl/usart_spi_defines.svh
// constants for the usart master spi transfer block
// Behaviour
// [R01] Software enables the transmitter before any transfer; it drives the clock.
// [R02] Enabled transmitter takes the serial output pin and drives shift data.
// [R03] Enabled receiver takes the serial input pin and feeds the shifter.
// [R04] Transfer clock pin carries the shift clock whenever the transmitter is on.
// [R05] A write to the data location starts a frame, also for receive.
// [R06] Written byte waits in the buffer until the shifter is free.
// [R07] Software reads the data location once per byte sent.
// [R08] On receive overflow the newest byte is dropped, older ones kept.
// [R09] Frame error, overrun and parity error bits always read zero.
// [R10] Transmit path is double buffered during shifting.
// [R11] No write collision flag, no double speed bit; rate set by divisor.
// [R12] Master only, no slave select; out is MOSI, in MISO, clock SCK.
// [R13] Polarity, phase and bit order behave like standard SPI settings.
// [R14] Status bit 7 is high while the receive buffer holds unread data.
// [R15] Disabling the receiver flushes the buffer and clears bit 7.
// [R16] Status bit 6 sets when a frame ends with no byte waiting.
// [R17] Bit 6 clears on interrupt service or a written one.
// [R18] Status bit 5 reads one while the transmit buffer can take a byte.
// [R19] Status bit 5 is set after reset.
// [R20] Software writes zeros to status bits 4 to 0.
// [R21] Receive interrupt needs control bit 7, global flag and bit 7 flag.
// [R22] Transmit interrupt needs control bit 6, global flag and bit 6 flag.
// [R23] Frames are eight bits and may follow back to back.
// [R24] Shift and sample on opposite edges; phase and polarity set which.
// [R25] Bit order one sends LSB first, zero MSB first, shared by both.
// [R26] Clock rate is system clock over two times divisor plus one.
// [R27] Empty interrupt needs its enable, global flag and empty flag.
// [R28] Transmit disable waits until shifter and buffer are empty.
`ifndef USART_SPI_DEFINES_SVH
`define USART_SPI_DEFINES_SVH

`define ADDR_STATUS 3'h0
`define ADDR_CONTROL 3'h1
`define ADDR_CONFIG 3'h2
`define ADDR_BAUD_LO 3'h3
`define ADDR_BAUD_HI 3'h4
`define ADDR_DATA 3'h5

`define ST_RXC 7
`define ST_TXC 6
`define ST_UDRE 5
`define CTL_RXCIE 7
`define CTL_TXCIE 6
`define CTL_BUFFER_EMPTY_IRQ_ENABLE 5
`define CTL_RXEN 4
`define CTL_TXEN 3
`define CTL_MASK 8'hF8
`define CFG_ORDER 2
`define CFG_PHASE 1
`define CFG_POL 0
`define CFG_RESET 3'h6

`define HALF_FIRST 4'h0
`define HALF_LAST 4'hF
`define RX_DEPTH 2'h2

`endif

// ===== rtl/usart_spi_pkg.sv
// types for the usart master spi transfer block
package usart_spi_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_SHIFT = 2'b10
  } spi_state_t;

  typedef struct packed {
    spi_state_t state;
    logic [7:0] ctrl;
    logic [2:0] cfg;
    logic [11:0] baud;
    logic [11:0] cnt;
    logic [3:0] half;
    logic sck;
    logic tx_on;
    logic [7:0] tx_buf;
    logic buf_full;
    logic [7:0] tx_sr;
    logic [7:0] rx_sr;
    logic [1:0][7:0] rx_buf;
    logic [1:0] rx_count;
    logic txc;
    logic [7:0] rdata;
    logic sout;
    logic rx_irq;
    logic tx_irq;
    logic udre_irq;
  } spi_regs_t;

endpackage

// ===== verif/spi_slave_model.sv
// behavioural spi slave for the far side of the transfer clock pin
`timescale 1ns/1ps
`default_nettype none
module spi_slave_model (
  input wire logic sck_i,
  input wire logic mosi_i,
  input wire logic cpha_i,
  input wire logic lsb_i,
  input wire logic sync_i,
  input wire logic [7:0] reply_i,
  output logic miso_o,
  output logic [7:0] got_o,
  output logic [7:0] frames_o
);
  logic [7:0] tx;
  logic [7:0] rx;
  int k;
  // sample what stood before the edge, not what the edge launches
  wire mosi_late;
  assign #1 mosi_late = mosi_i;
  function automatic logic pick(input logic [7:0] b, input int i);
    return lsb_i ? b[i] : b[7-i];
  endfunction
  initial begin
    miso_o = 1'b0;
    got_o = 8'h00;
    frames_o = 8'h00;
    rx = 8'h00;
    tx = 8'h00;
    k = 0;
  end
  // realign after a mode change, whose idle level step looks like an edge
  always @(posedge sync_i) begin
    k = 0;
    tx = reply_i + frames_o;
    miso_o = pick(tx, 0);
  end
  // odd edges lead, even edges trail
  always @(sck_i) begin
    k++;
    if ((k % 2 == 1) == !cpha_i) begin
      rx = lsb_i ? {mosi_late, rx[7:1]} : {rx[6:0], mosi_late};
    end else if (k < 16) begin
      miso_o = pick(tx, k / 2);
    end
    if (k == 16) begin
      k = 0;
      got_o = rx;
      frames_o = frames_o + 8'h01;
      tx = reply_i + frames_o;
      miso_o = cpha_i ? ~miso_o : pick(tx, 0);
    end
  end
endmodule
`default_nettype wire

// ===== verif/testbench.sv
// register level testbench for the usart master spi transfer block
`timescale 1ns/1ps
`default_nettype none
`include "usart_spi_defines.svh"
module testbench;
  logic clock_i, rst_n_i, ws, rs, gie, ack, port, miso, cpha, lsb, sync;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, got, frames, reply, nf, s;
  logic mosi, oov, iov, sck, rxi, txi, bei;
  int err_count, compares, cyc;
  time t_last, per;
  usart_master_spi_transfer dut_u (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .address_i(addr),
    .write_data_i(wdata), .write_strobe_i(ws), .read_strobe_i(rs),
    .read_data_o(rdata), .global_irq_enable_i(gie),
    .tx_complete_irq_ack_i(ack), .port_out_i(port),
    .serial_out_pin_o(mosi), .serial_out_override_o(oov),
    .serial_in_pin_i(miso), .serial_in_override_o(iov),
    .transfer_clock_pin_o(sck), .rx_complete_irq_o(rxi),
    .tx_complete_irq_o(txi), .buffer_empty_irq_o(bei));
  spi_slave_model slave_u (
    .sck_i(sck), .mosi_i(mosi), .cpha_i(cpha), .lsb_i(lsb), .sync_i(sync),
    .reply_i(reply), .miso_o(miso), .got_o(got), .frames_o(frames));
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  always @(posedge sck) begin
    per = $time - t_last;
    t_last = $time;
  end
  task end_of_test;
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      end_of_test();
    end
  end
  task tick(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", n, e, g);
      err_count++;
    end
  endtask
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock_i);
    addr <= a;
    wdata <= d;
    ws <= 1'b1;
    @(posedge clock_i);
    ws <= 1'b0;
  endtask
  task rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clock_i);
    addr <= a;
    rs <= 1'b1;
    @(posedge clock_i);
    rs <= 1'b0;
    @(negedge clock_i);
    d = rdata;
  endtask
  task poll(input logic [7:0] m);
    logic [7:0] v;
    for (int i = 0; i < 400; i++) begin
      rd(`ADDR_STATUS, v);
      if ((v & m) === m) break;
    end
    chk("status poll", m, v & m);
  endtask
  task xfer(input logic [7:0] d);
    logic [7:0] v;
    wr(`ADDR_DATA, d);
    poll(8'h40);
    chk("slave byte", d, got);
    rd(`ADDR_DATA, v);
    chk("reply", 8'(reply + nf), v);
    nf = nf + 8'h01;
    wr(`ADDR_STATUS, 8'h40);
    rd(`ADDR_STATUS, v);
    chk("status", 8'h20, v);
  endtask
  initial begin
    {rst_n_i, ws, rs, gie, ack, port, sync} = '0;
    addr = 3'h0;
    wdata = 8'h00;
    {cpha, lsb} = 2'b11;
    reply = 8'h3C;
    nf = 8'h00;
    tick(5);
    rst_n_i <= 1'b1;
    rd(`ADDR_STATUS, s);
    chk("status reset", 8'h20, s);
    rd(`ADDR_CONFIG, s);
    chk("config reset", 8'h06, s);
    chk("out override off", 8'h00, oov);
    rd(3'h6, s);
    chk("unmapped", 8'h00, s);
    wr(3'h7, 8'hFF);
    rd(`ADDR_CONTROL, s);
    chk("control", 8'h00, s);
    wr(`ADDR_CONTROL, 8'h18);
    tick(2);
    chk("out override", 8'h01, oov);
    chk("in override", 8'h01, iov);
    for (int m = 0; m < 8; m++) begin
      lsb = m[2];
      cpha = m[1];
      wr(`ADDR_BAUD_LO, (m == 5) ? 8'h02 : 8'h00);
      wr(`ADDR_CONFIG, 8'(m));
      tick(2);
      sync <= 1'b1;
      tick(1);
      sync <= 1'b0;
      xfer(8'(8'hA1 + m * 37));
      chk("sck idle", 8'(m % 2), sck);
      chk("sck period", (m == 5) ? 8'd60 : 8'd20, 8'(per));
    end
    wr(`ADDR_DATA, 8'h11);
    poll(8'h20);
    wr(`ADDR_DATA, 8'h22);
    rd(`ADDR_STATUS, s);
    chk("empty while full", 8'h00, s[5]);
    poll(8'h20);
    wr(`ADDR_DATA, 8'h33);
    poll(8'h20);
    wr(`ADDR_DATA, 8'h44);
    poll(8'h40);
    chk("last byte", 8'h44, got);
    rd(`ADDR_DATA, s);
    chk("oldest", 8'(reply + nf), s);
    rd(`ADDR_DATA, s);
    chk("second", 8'(reply + nf + 1), s);
    rd(`ADDR_STATUS, s);
    chk("rx empty", 8'h60, s);
    nf = nf + 8'h04;
    wr(`ADDR_STATUS, 8'h40);
    wr(`ADDR_CONTROL, 8'hF8);
    wr(`ADDR_DATA, 8'h5A);
    poll(8'h40);
    tick(2);
    chk("irqs masked", 8'h00, {rxi, txi, bei});
    gie <= 1'b1;
    tick(2);
    chk("irqs", 8'h07, {rxi, txi, bei});
    ack <= 1'b1;
    tick(1);
    ack <= 1'b0;
    tick(2);
    chk("tx irq cleared", 8'h00, txi);
    wr(`ADDR_CONTROL, 8'hE8);
    tick(3);
    chk("rx irq flushed", 8'h00, rxi);
    chk("in override off", 8'h00, iov);
    rd(`ADDR_STATUS, s);
    chk("flushed", 8'h20, s);
    nf = nf + 8'h01;
    wr(`ADDR_CONTROL, 8'h08);
    wr(`ADDR_DATA, 8'h96);
    wr(`ADDR_CONTROL, 8'h00);
    tick(3);
    chk("disable pending", 8'h01, oov);
    poll(8'h40);
    tick(2);
    chk("released", 8'h00, oov);
    chk("port low", 8'h00, mosi);
    chk("tx only byte", 8'h96, got);
    port <= 1'b1;
    tick(2);
    chk("port value", 8'h01, mosi);
    end_of_test();
  end
endmodule
`default_nettype wire
